// *** src/dcs_regs.sv ***
// Drive command and status register bank behind the serial link decoder.
//
// How it works
// - Parameter address: group high byte, index low
// - Command word decodes run and direction codes
// - Bits 7..6 pick one of four ramps
// - Bits 11..8 pick master or stage speed
// - Bit 12 enables its referenced function
// - Bits 14..13 set operation command source
// - Fault word: external fault, reset, base block
// - Status word: warning high byte, error low
// - State word reports drive state and jog
// - State word bits 4..3 report direction
// - Single write echoes address and value
// - Block write limited to twenty words
`default_nettype none
module dcs_regs
#(
    parameter int MAX_WORDS = dcs_pkg::DCS_MAX_WORDS
)
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_req_valid,
    input  wire dcs_pkg::dcs_req_s      i_req,
    output logic                        o_req_ready,
    input  wire logic                   i_word_valid,
    input  wire logic [15:0]            i_word,
    output logic                        o_word_ready,
    output logic                        o_rsp_valid,
    output dcs_pkg::dcs_rsp_s           o_rsp,
    input  wire logic                   i_rd_valid,
    input  wire logic [15:0]            i_rd_addr,
    output logic                        o_rd_valid,
    output logic [15:0]                 o_rd_data,
    output logic                        o_rd_exc,
    input  wire dcs_pkg::dcs_status_s   i_status,
    output dcs_pkg::dcs_drive_cmd_s     o_cmd,
    output logic [15:0]                 o_freq_cmd,
    output logic                        o_ext_fault,
    output logic                        o_fault_reset,
    output logic                        o_base_block,
    output logic                        o_param_wr,
    output dcs_pkg::dcs_param_wr_s      o_param
);
    import dcs_pkg::*;

    logic        wr_valid;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;

    dcs_drive_cmd_s cmd_r,       cmd_nxt;
    logic [15:0]    freq_r,      freq_nxt;
    logic           ext_r,       ext_nxt;
    logic           frst_r,      frst_nxt;
    logic           bb_r,        bb_nxt;
    logic           pwr_r,       pwr_nxt;
    dcs_param_wr_s  param_r,     param_nxt;
    logic           rd_valid_r,  rd_valid_nxt;
    logic [15:0]    rd_data_r,   rd_data_nxt;
    logic           rd_exc_r,    rd_exc_nxt;

    // ------------------------------------------------------------------
    // Write splitting
    // ------------------------------------------------------------------
    dcs_write_seq #(
        .MAX_WORDS (MAX_WORDS)
    ) u_seq (
        .i_core_clk   (i_core_clk),
        .i_resetn     (i_resetn),
        .i_req_valid  (i_req_valid),
        .i_req        (i_req),
        .o_req_ready  (o_req_ready),
        .i_word_valid (i_word_valid),
        .i_word       (i_word),
        .o_word_ready (o_word_ready),
        .o_wr_valid   (wr_valid),
        .o_wr_addr    (wr_addr),
        .o_wr_data    (wr_data),
        .o_rsp_valid  (o_rsp_valid),
        .o_rsp        (o_rsp)
    );

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    always_comb
    begin
        cmd_nxt         = cmd_r;
        cmd_nxt.run_stb = 1'b0;
        cmd_nxt.dir_stb = 1'b0;
        cmd_nxt.src_stb = 1'b0;
        freq_nxt        = freq_r;
        ext_nxt         = 1'b0;
        frst_nxt        = 1'b0;
        bb_nxt          = bb_r;
        pwr_nxt         = 1'b0;
        param_nxt       = param_r;
        if (wr_valid)
        begin
            // Only named fields are taken; reserved bits fall away.
            case (wr_addr)
                DCS_ADDR_CMD:
                begin
                    cmd_nxt.run_code  = wr_data[DCS_CMD_RUN_LSB +: 2];
                    cmd_nxt.run_stb   = wr_data[DCS_CMD_RUN_LSB +: 2]
                                        != DCS_CODE_NONE;
                    cmd_nxt.dir_code  = wr_data[DCS_CMD_DIR_LSB +: 2];
                    cmd_nxt.dir_stb   = wr_data[DCS_CMD_DIR_LSB +: 2]
                                        != DCS_CODE_NONE;
                    cmd_nxt.ramp_sel  = wr_data[DCS_CMD_RAMP_LSB +: 2];
                    cmd_nxt.speed_sel = wr_data[DCS_CMD_SPEED_LSB +: 4];
                    cmd_nxt.func_en   = wr_data[DCS_CMD_FUNC_BIT];
                    cmd_nxt.src_code  = wr_data[DCS_CMD_SRC_LSB +: 2];
                    cmd_nxt.src_stb   = wr_data[DCS_CMD_SRC_LSB +: 2]
                                        != DCS_CODE_NONE;
                end
                DCS_ADDR_FREQ:
                begin
                    freq_nxt = wr_data;
                end
                DCS_ADDR_FAULT:
                begin
                    ext_nxt  = wr_data[DCS_FLT_EXT_BIT];
                    frst_nxt = wr_data[DCS_FLT_RST_BIT];
                    bb_nxt   = wr_data[DCS_FLT_BB_BIT];
                end
                default:
                begin
                    // Status words ignore writes; low groups are parameters.
                    if (wr_addr[15:8] < DCS_PARAM_GRP_LIMIT)
                    begin
                        pwr_nxt   = 1'b1;
                        param_nxt = '{wr_addr[15:8], wr_addr[7:0],
                                      wr_data};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cmd_r   <= '0;
            freq_r  <= '0;
            ext_r   <= 1'b0;
            frst_r  <= 1'b0;
            bb_r    <= 1'b0;
            pwr_r   <= 1'b0;
            param_r <= '0;
        end
        else
        begin
            cmd_r   <= cmd_nxt;
            freq_r  <= freq_nxt;
            ext_r   <= ext_nxt;
            frst_r  <= frst_nxt;
            bb_r    <= bb_nxt;
            pwr_r   <= pwr_nxt;
            param_r <= param_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_valid_nxt = i_rd_valid;
        rd_data_nxt  = rd_data_r;
        rd_exc_nxt   = 1'b0;
        if (i_rd_valid)
        begin
            rd_data_nxt = '0;
            case (i_rd_addr)
                DCS_ADDR_WARN:
                begin
                    rd_data_nxt = {i_status.warn, i_status.err};
                end
                DCS_ADDR_STATE:
                begin
                    rd_data_nxt[DCS_ST_STATE_LSB +: 2] =
                        i_status.run_state;
                    rd_data_nxt[DCS_ST_JOG_BIT] = i_status.jog;
                    rd_data_nxt[DCS_ST_DIR_LSB +: 2] =
                        i_status.dir_state;
                end
                default:
                begin
                    // Command words are write-only and answer with an error.
                    rd_exc_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
            rd_exc_r   <= 1'b0;
        end
        else
        begin
            rd_valid_r <= rd_valid_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_exc_r   <= rd_exc_nxt;
        end
    end

    assign o_cmd         = cmd_r;
    assign o_freq_cmd    = freq_r;
    assign o_ext_fault   = ext_r;
    assign o_fault_reset = frst_r;
    assign o_base_block  = bb_r;
    assign o_param_wr    = pwr_r;
    assign o_param       = param_r;
    assign o_rd_valid    = rd_valid_r;
    assign o_rd_data     = rd_data_r;
    assign o_rd_exc      = rd_exc_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    logic wr_cmd;
    assign wr_cmd = wr_valid && wr_addr == DCS_ADDR_CMD;

    param_map_a: assert property (
        wr_valid && wr_addr[15:8] < DCS_PARAM_GRP_LIMIT |=> o_param_wr &&
        o_param.group == $past(wr_addr[15:8]) &&
        o_param.index == $past(wr_addr[7:0]))
        else $error("parameter write not mapped by group and index");
    run_code_a: assert property (
        wr_cmd |=> o_cmd.run_stb == ($past(wr_data[1:0]) != 2'h0) &&
        o_cmd.run_code == $past(wr_data[1:0]))
        else $error("run code not decoded");
    dir_code_a: assert property (
        wr_cmd |=> o_cmd.dir_stb == ($past(wr_data[5:4]) != 2'h0) &&
        o_cmd.dir_code == $past(wr_data[5:4]))
        else $error("direction code not decoded");
    ramp_hold_a: assert property (
        wr_cmd ##1 !wr_cmd [*2] |-> o_cmd.ramp_sel == $past(wr_data[7:6], 2))
        else $error("ramp select not held");
    speed_sel_a: assert property (
        wr_cmd |=> o_cmd.speed_sel == $past(wr_data[11:8]))
        else $error("speed select wrong");
    func_en_a: assert property (
        wr_cmd |=> o_cmd.func_en == $past(wr_data[12]))
        else $error("function enable wrong");
    src_code_a: assert property (
        wr_cmd |=> o_cmd.src_stb == ($past(wr_data[14:13]) != 2'h0) &&
        o_cmd.src_code == $past(wr_data[14:13]))
        else $error("source code not decoded");
    fault_word_a: assert property (
        wr_valid && wr_addr == DCS_ADDR_FAULT |=>
        o_ext_fault == $past(wr_data[0]) &&
        o_fault_reset == $past(wr_data[1]) &&
        o_base_block == $past(wr_data[2]) ##1 !o_ext_fault || $past(wr_valid))
        else $error("fault word effect wrong");
    warn_err_a: assert property (
        i_rd_valid && i_rd_addr == DCS_ADDR_WARN |=>
        o_rd_valid && !o_rd_exc &&
        o_rd_data == $past({i_status.warn, i_status.err}))
        else $error("warning or error code wrong");
    run_state_a: assert property (
        i_rd_valid && i_rd_addr == DCS_ADDR_STATE |=>
        o_rd_data[1:0] == $past(i_status.run_state) &&
        o_rd_data[2] == $past(i_status.jog))
        else $error("drive state wrong");
    dir_state_a: assert property (
        i_rd_valid && i_rd_addr == DCS_ADDR_STATE |=>
        o_rd_data[4:3] == $past(i_status.dir_state) &&
        o_rd_data[15:5] == 11'h000)
        else $error("direction state wrong");
    echo_a: assert property (
        o_rsp_valid && !o_rsp.exc && o_rsp.func == DCS_FC_WRITE1 |->
        wr_valid && o_rsp.addr == wr_addr && o_rsp.value == wr_data)
        else $error("single write echo wrong");
    max_words_a: assert property (
        i_req_valid && o_req_ready && i_req.func == DCS_FC_WRITEN &&
        i_req.qty > 16'(MAX_WORDS) |=> o_rsp_valid && o_rsp.exc && !wr_valid)
        else $error("oversize block write accepted");
    reserved_a: assert property (
        wr_cmd && wr_data[14:13] == 2'h0 && wr_data[5:0] == 6'h00 |=>
        !o_cmd.run_stb && !o_cmd.dir_stb && !o_cmd.src_stb)
        else $error("reserved bits caused an action");

    block_write_c: cover property (
        o_rsp_valid && !o_rsp.exc && o_rsp.func == DCS_FC_WRITEN);
    run_cmd_c: cover property (o_cmd.run_stb && o_cmd.run_code == 2'h3);
    base_block_c: cover property (o_base_block);
    status_read_c: cover property (o_rd_valid && !o_rd_exc);

endmodule : dcs_regs
`default_nettype wire

// *** include/dcs_pkg.sv ***
// Shared constants and carrier types for the drive command/status bank.
`default_nettype none
package dcs_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] DCS_ADDR_CMD   = 16'h2000;
    localparam logic [15:0] DCS_ADDR_FREQ  = 16'h2001;
    localparam logic [15:0] DCS_ADDR_FAULT = 16'h2002;
    localparam logic [15:0] DCS_ADDR_WARN  = 16'h2100;
    localparam logic [15:0] DCS_ADDR_STATE = 16'h2101;
    // Groups below this value address drive parameters.
    localparam logic [7:0]  DCS_PARAM_GRP_LIMIT = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int DCS_CMD_RUN_LSB   = 0;
    localparam int DCS_CMD_DIR_LSB   = 4;
    localparam int DCS_CMD_RAMP_LSB  = 6;
    localparam int DCS_CMD_SPEED_LSB = 8;
    localparam int DCS_CMD_FUNC_BIT  = 12;
    localparam int DCS_CMD_SRC_LSB   = 13;
    localparam int DCS_FLT_EXT_BIT   = 0;
    localparam int DCS_FLT_RST_BIT   = 1;
    localparam int DCS_FLT_BB_BIT    = 2;
    localparam int DCS_ST_STATE_LSB  = 0;
    localparam int DCS_ST_JOG_BIT    = 2;
    localparam int DCS_ST_DIR_LSB    = 3;
    localparam logic [1:0] DCS_CODE_NONE = 2'h0;

    // ------------------------------------------------------------------
    // Function codes and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] DCS_FC_READ   = 8'h03;
    localparam logic [7:0] DCS_FC_WRITE1 = 8'h06;
    localparam logic [7:0] DCS_FC_WRITEN = 8'h10;
    localparam int         DCS_MAX_WORDS = 20;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] qty;
    } dcs_req_s;

    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] value;
        logic        exc;
    } dcs_rsp_s;

    typedef struct packed {
        logic       run_stb;
        logic [1:0] run_code;
        logic       dir_stb;
        logic [1:0] dir_code;
        logic       src_stb;
        logic [1:0] src_code;
        logic [1:0] ramp_sel;
        logic [3:0] speed_sel;
        logic       func_en;
    } dcs_drive_cmd_s;

    typedef struct packed {
        logic [7:0] warn;
        logic [7:0] err;
        logic [1:0] run_state;
        logic       jog;
        logic [1:0] dir_state;
    } dcs_status_s;

    typedef struct packed {
        logic [7:0]  group;
        logic [7:0]  index;
        logic [15:0] data;
    } dcs_param_wr_s;

endpackage : dcs_pkg
`default_nettype wire

// *** src/dcs_write_seq.sv ***
// Splits single and multiple register write requests into word writes.
`default_nettype none
module dcs_write_seq
#(
    parameter int MAX_WORDS = dcs_pkg::DCS_MAX_WORDS
)
(
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_req_valid,
    input  wire dcs_pkg::dcs_req_s i_req,
    output logic                   o_req_ready,
    input  wire logic              i_word_valid,
    input  wire logic [15:0]       i_word,
    output logic                   o_word_ready,
    output logic                   o_wr_valid,
    output logic [15:0]            o_wr_addr,
    output logic [15:0]            o_wr_data,
    output logic                   o_rsp_valid,
    output dcs_pkg::dcs_rsp_s      o_rsp
);
    import dcs_pkg::*;

    typedef enum logic {DCS_IDLE, DCS_DATA} dcs_seq_e;

    dcs_seq_e    state_r,    state_nxt;
    logic [15:0] addr_r,     addr_nxt;
    logic [15:0] left_r,     left_nxt;
    dcs_req_s    req_r,      req_nxt;
    logic        wr_valid_r, wr_valid_nxt;
    logic [15:0] wr_addr_r,  wr_addr_nxt;
    logic [15:0] wr_data_r,  wr_data_nxt;
    logic        rsp_valid_r, rsp_valid_nxt;
    dcs_rsp_s    rsp_r,      rsp_nxt;

    localparam logic [15:0] MAX_QTY = 16'(MAX_WORDS);

    assign o_req_ready  = (state_r == DCS_IDLE);
    assign o_word_ready = (state_r == DCS_DATA);

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt     = state_r;
        addr_nxt      = addr_r;
        left_nxt      = left_r;
        req_nxt       = req_r;
        wr_valid_nxt  = 1'b0;
        wr_addr_nxt   = wr_addr_r;
        wr_data_nxt   = wr_data_r;
        rsp_valid_nxt = 1'b0;
        rsp_nxt       = rsp_r;
        case (state_r)
            DCS_IDLE:
            begin
                if (i_req_valid)
                begin
                    req_nxt  = i_req;
                    addr_nxt = i_req.addr;
                    if (i_req.func == DCS_FC_WRITE1)
                    begin
                        left_nxt  = 16'h0001;
                        state_nxt = DCS_DATA;
                    end
                    else if (i_req.func == DCS_FC_WRITEN &&
                             i_req.qty != 16'h0000 &&
                             i_req.qty <= MAX_QTY)
                    begin
                        left_nxt  = i_req.qty;
                        state_nxt = DCS_DATA;
                    end
                    else
                    begin
                        // Too many words, none, or an unknown function.
                        rsp_valid_nxt = 1'b1;
                        rsp_nxt       = '{i_req.func, i_req.addr,
                                          i_req.qty, 1'b1};
                    end
                end
            end
            DCS_DATA:
            begin
                if (i_word_valid)
                begin
                    wr_valid_nxt = 1'b1;
                    wr_addr_nxt  = addr_r;
                    wr_data_nxt  = i_word;
                    addr_nxt     = addr_r + 16'h0001;
                    left_nxt     = left_r - 16'h0001;
                    if (left_r == 16'h0001)
                    begin
                        state_nxt     = DCS_IDLE;
                        rsp_valid_nxt = 1'b1;
                        // Single writes echo the value, block writes the count.
                        rsp_nxt = '{req_r.func, req_r.addr,
                                    (req_r.func == DCS_FC_WRITE1) ?
                                    i_word : req_r.qty, 1'b0};
                    end
                end
            end
            default:
            begin
                state_nxt = DCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r     <= DCS_IDLE;
            addr_r      <= '0;
            left_r      <= '0;
            req_r       <= '0;
            wr_valid_r  <= 1'b0;
            wr_addr_r   <= '0;
            wr_data_r   <= '0;
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end
        else
        begin
            state_r     <= state_nxt;
            addr_r      <= addr_nxt;
            left_r      <= left_nxt;
            req_r       <= req_nxt;
            wr_valid_r  <= wr_valid_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wr_data_r   <= wr_data_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r       <= rsp_nxt;
        end
    end

    assign o_wr_valid  = wr_valid_r;
    assign o_wr_addr   = wr_addr_r;
    assign o_wr_data   = wr_data_r;
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp       = rsp_r;

endmodule : dcs_write_seq
`default_nettype wire

// *** test/dcs_master_model.sv ***
// Link master model that issues register write requests to the bank.
`default_nettype none
module dcs_master_model
(
    input  wire logic              i_core_clk,
    input  wire logic              i_req_ready,
    input  wire logic              i_word_ready,
    input  wire logic              i_rsp_valid,
    input  wire dcs_pkg::dcs_rsp_s i_rsp,
    output logic                   o_req_valid,
    output dcs_pkg::dcs_req_s      o_req,
    output logic                   o_word_valid,
    output logic [15:0]            o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;

    initial
    begin
        o_req_valid  = 1'b0;
        o_req        = '0;
        o_word_valid = 1'b0;
        o_word       = 16'h0000;
    end

    // Idle data line toggles so a stale word is never mistaken for data.
    task automatic wr(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] q, input logic [15:0] w,
                      output dcs_rsp_s rsp);
        int k;
        int n;
        k = 0;
        n = (f == DCS_FC_WRITE1) ? 1 :
            (f == DCS_FC_WRITEN) ? int'(q) : 0;
        rsp = '0;
        o_req_valid <= 1'b1;
        o_req       <= '{f, a, q};
        @(posedge i_core_clk);
        while (!i_req_ready)
        begin
            @(posedge i_core_clk);
        end
        o_req_valid <= 1'b0;
        repeat (64)
        begin
            o_word_valid <= (k < n);
            o_word       <= (k < n) ? w + 16'(k) : ~o_word;
            @(posedge i_core_clk);
            if (o_word_valid && i_word_ready)
                k++;
            if (i_rsp_valid)
            begin
                rsp = i_rsp;
                break;
            end
        end
        o_word_valid <= 1'b0;
    endtask : wr
endmodule : dcs_master_model
`default_nettype wire

// *** test/drive_command_status_regs_bench.sv ***
// Self-checking bench for the drive command and status register bank.
`default_nettype none
module drive_command_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;

    logic           core_clk, resetn, req_valid, req_ready, word_valid;
    logic           word_ready, rsp_valid, rd_valid, rd_ok, rd_exc;
    logic           param_wr, ext_fault, fault_rst, base_blk;
    logic [15:0]    word, rd_addr, rd_data, freq;
    logic [7:0]     param_cnt;
    dcs_req_s       req;
    dcs_rsp_s       rsp, r;
    dcs_status_s    status;
    dcs_drive_cmd_s cmd;
    dcs_param_wr_s  param, last_param;
    int             bad_count = 0;
    int             checks_done = 0;
    int             cycles = 0;

    dcs_regs dut_u (.i_core_clk(core_clk), .i_resetn(resetn),
        .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
        .i_word_valid(word_valid), .i_word(word), .o_word_ready(word_ready),
        .o_rsp_valid(rsp_valid), .o_rsp(rsp), .i_rd_valid(rd_valid),
        .i_rd_addr(rd_addr), .o_rd_valid(rd_ok), .o_rd_data(rd_data),
        .o_rd_exc(rd_exc), .i_status(status), .o_cmd(cmd),
        .o_freq_cmd(freq), .o_ext_fault(ext_fault),
        .o_fault_reset(fault_rst), .o_base_block(base_blk),
        .o_param_wr(param_wr), .o_param(param));

    dcs_master_model m_u (.i_core_clk(core_clk), .i_req_ready(req_ready),
        .i_word_ready(word_ready), .i_rsp_valid(rsp_valid), .i_rsp(rsp),
        .o_req_valid(req_valid), .o_req(req), .o_word_valid(word_valid),
        .o_word(word));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic [15:0] exp,
                      input logic exc);
        rd_valid <= 1'b1;
        rd_addr  <= a;
        @(posedge core_clk);
        rd_valid <= 1'b0;
        rd_addr  <= ~a;
        @(posedge core_clk);
        chk({rd_ok, rd_exc, rd_data}, {1'b1, exc, exp});
    endtask : rd

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            param_cnt <= 8'h00;
        else if (param_wr === 1'b1)
        begin
            param_cnt  <= param_cnt + 8'h01;
            last_param <= param;
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reserved bits are written as ones to show they are ignored.
    task automatic t_cmd;
        logic        s;
        logic [1:0]  c;
        logic [15:0] w;
        for (int i = 0; i < 4; i++)
        begin
            s = (i != 0);
            c = 2'(i);
            w = {1'b1, c, c[0], c, c, c, c, 2'b11, c};
            m_u.wr(DCS_FC_WRITE1, DCS_ADDR_CMD, 16'h0001, w, r);
            chk(r, {DCS_FC_WRITE1, DCS_ADDR_CMD, w, 1'b0});
            @(posedge core_clk);
            chk(cmd, {s,c,s,c,s,c,c,c,c,c[0]});
        end
    endtask : t_cmd

    task automatic t_fault;
        m_u.wr(DCS_FC_WRITEN, DCS_ADDR_FREQ, 16'h0002, 16'h1236, r);
        chk(r, {DCS_FC_WRITEN, DCS_ADDR_FREQ, 16'h0002, 1'b0});
        @(posedge core_clk);
        chk({freq, ext_fault, fault_rst, base_blk}, {16'h1236, 3'h7});
        m_u.wr(DCS_FC_WRITE1, DCS_ADDR_FAULT, 16'h0001, 16'h0000, r);
        @(posedge core_clk);
        chk({freq, ext_fault, fault_rst, base_blk}, {16'h1236, 3'h0});
    endtask : t_fault

    task automatic t_block;
        m_u.wr(DCS_FC_WRITEN, 16'h0400, 16'h0000, 16'h0100, r);
        chk(r.exc, 1'b1);
        m_u.wr(DCS_FC_WRITEN, 16'h0400, 16'h0015, 16'h0100, r);
        chk(r, {DCS_FC_WRITEN, 16'h0400, 16'h0015, 1'b1});
        m_u.wr(DCS_FC_READ, 16'h0400, 16'h0001, 16'h0100, r);
        chk(r.exc, 1'b1);
        m_u.wr(DCS_FC_WRITEN, 16'h0400, 16'h0014, 16'h0100, r);
        repeat (2) @(posedge core_clk);
        chk(param_cnt, 8'h14);
        chk(last_param, {8'h04, 8'h13, 16'h0113});
    endtask : t_block

    task automatic t_read;
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            status <= {8'ha0 + 8'(i), 8'h5f - 8'(i), c, c[0], ~c};
            rd(DCS_ADDR_WARN, {8'ha0 + 8'(i), 8'h5f - 8'(i)}, 1'b0);
            rd(DCS_ADDR_STATE, {11'h000, ~c, c[0], c}, 1'b0);
        end
        rd(DCS_ADDR_CMD, 16'h0000, 1'b1);
    endtask : t_read

    // ------------------------------------------------------------------
    // Clock, reset, sequence and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial
    begin
        resetn   = 1'b0;
        rd_valid = 1'b0;
        rd_addr  = 16'h0000;
        status   = '0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_cmd();
        t_fault();
        t_block();
        t_read();
        summarize();
    end

    // The whole sequence needs well under a thousand cycles.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end
endmodule : drive_command_status_regs_bench
`default_nettype wire
